// ===== eeprom_pkg.sv
// Constants shared by the two-wire serial memory slave.
// Assumes a single 125 MHz system clock.
package eeprom_pkg;

   // ****************************************
   // Array geometry
   // ****************************************
   localparam int ADDR_W = 9;
   localparam int MEM_BYTES = 512;
   localparam int PAGE_BYTES = 16;
   localparam int PAGE_IDX_W = 4;
   localparam int BYTE_BITS = 8;
   localparam logic [3:0] BIT_COUNT_FULL = 4'h8;

   // ****************************************
   // Slave address byte fields
   // ****************************************
   localparam int SLV_TYPE_HI = 7;
   localparam int SLV_TYPE_LO = 4;
   localparam int SLV_SEL_HIGH = 3;
   localparam int SLV_SEL_LOW = 2;
   localparam int SLV_MSB = 1;
   localparam int SLV_RW = 0;

   // ****************************************
   // Write cycle timing
   // ****************************************
   localparam int CLK_HZ = 125_000_000;
   localparam int WRITE_CYCLE_MS = 5;
   localparam int WRITE_CYCLE_CLKS = WRITE_CYCLE_MS * (CLK_HZ / 1000);
   localparam int TIMER_W = 20;

   // ****************************************
   // Protocol states
   // ****************************************
   typedef enum logic [3:0] {
      ST_IDLE,
      ST_WAIT,
      ST_DEVADDR,
      ST_DEVACK,
      ST_WORDADDR,
      ST_WORDACK,
      ST_WDATA,
      ST_WDACK,
      ST_RDATA,
      ST_RACK
   } proto_state_type;

endpackage

// ===== pin_sync.sv
// Two-stage synchroniser for a group of pin inputs.
// Assumes inputs are asynchronous to clk.
`timescale 1ns/100ps
module pin_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Pins in, synchronised levels out
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_sync_out
);

   logic [WIDTH-1:0] stage1_r;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stage1_r <= '0;
         pin_sync_out <= '0;
      end else begin
         stage1_r <= pin_in;
         pin_sync_out <= stage1_r;
      end
   end

endmodule

// ===== twowire_eeprom_slave.sv
// Two-wire slave front end with a 512-byte array behind it.
// Assumes bus pins are asynchronous and sampled by clk; SDA is open drain.
`timescale 1ns/100ps
module twowire_eeprom_slave #(
   parameter logic [3:0] DEVICE_TYPE_ID = 4'h5, // Arbitrary value
   parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLE_CLKS
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Two-wire bus
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   // Straps
   input wire logic write_protect,
   input wire logic chip_select_pin_low,
   input wire logic chip_select_pin_high,
   // Status
   output logic write_busy
);

   // ****************************************
   // Pin synchronisers and bus events
   // ****************************************
   logic [4:0] pins_s;
   logic scl_s, sda_s, wp_s, sel_low_s, sel_high_s;
   logic scl_d_r, sda_d_r;
   logic scl_rise, scl_fall, start_ev, stop_ev;

   pin_sync #(.WIDTH(5)) pin_sync_i (
      .clk(clk),
      .rst(rst),
      .pin_in({scl, sda_in, write_protect, chip_select_pin_low, chip_select_pin_high}),
      .pin_sync_out(pins_s)
   );

   assign {scl_s, sda_s, wp_s, sel_low_s, sel_high_s} = pins_s;
   assign scl_rise = scl_s & ~scl_d_r;
   assign scl_fall = ~scl_s & scl_d_r;
   assign start_ev = scl_s & scl_d_r & sda_d_r & ~sda_s;
   assign stop_ev = scl_s & scl_d_r & ~sda_d_r & sda_s;

   // ****************************************
   // State
   // ****************************************
   eeprom_pkg::proto_state_type state_r, state_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic [7:0] shift_r, shift_nxt, tx_r, tx_nxt;
   logic [eeprom_pkg::ADDR_W-1:0] addr_r, addr_nxt;
   logic rw_r, rw_nxt, oe_n_r, oe_n_nxt, busy_r, busy_nxt;
   logic ack_seen_r, ack_seen_nxt, have_r, have_nxt;
   logic [eeprom_pkg::TIMER_W-1:0] timer_r, timer_nxt;
   logic [4:0] wr_idx_r, wr_idx_nxt;
   logic [4:0] wpage_r, wpage_nxt;
   logic [eeprom_pkg::PAGE_BYTES-1:0] pvalid_r, pvalid_nxt;
   logic [7:0] pbuf_r [eeprom_pkg::PAGE_BYTES];
   logic [7:0] pbuf_nxt [eeprom_pkg::PAGE_BYTES];
   logic [7:0] mem [eeprom_pkg::MEM_BYTES];
   logic [7:0] rd_byte;
   logic sel_match, mem_we;

   assign rd_byte = mem[addr_r];
   assign sel_match = shift_r[eeprom_pkg::SLV_TYPE_HI:eeprom_pkg::SLV_TYPE_LO] == DEVICE_TYPE_ID
      && shift_r[eeprom_pkg::SLV_SEL_HIGH] == sel_high_s
      && shift_r[eeprom_pkg::SLV_SEL_LOW] == sel_low_s;
   assign mem_we = busy_r && !wr_idx_r[4] && pvalid_r[wr_idx_r[3:0]];

   // ****************************************
   // Next-state logic
   // ****************************************
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      shift_nxt = shift_r;
      tx_nxt = tx_r;
      addr_nxt = addr_r;
      rw_nxt = rw_r;
      oe_n_nxt = oe_n_r;
      busy_nxt = busy_r;
      ack_seen_nxt = ack_seen_r;
      have_nxt = have_r;
      timer_nxt = timer_r;
      wr_idx_nxt = wr_idx_r;
      wpage_nxt = wpage_r;
      pvalid_nxt = pvalid_r;
      pbuf_nxt = pbuf_r;
      if (busy_r) begin
         // Bus ignored while array is written
         state_nxt = eeprom_pkg::ST_WAIT;
         oe_n_nxt = 1'b1;
         if (!wr_idx_r[4]) begin
            wr_idx_nxt = wr_idx_r + 5'h01;
         end
         timer_nxt = timer_r - 20'h00001;
         if (timer_r == 20'h00001) begin
            busy_nxt = 1'b0;
            pvalid_nxt = '0;
            have_nxt = 1'b0;
            state_nxt = eeprom_pkg::ST_IDLE;
         end
      end else if (start_ev) begin
         // Repeated start also drops any pending page data
         state_nxt = eeprom_pkg::ST_DEVADDR;
         cnt_nxt = 4'h0;
         oe_n_nxt = 1'b1;
         pvalid_nxt = '0;
         have_nxt = 1'b0;
         ack_seen_nxt = 1'b0;
      end else if (stop_ev) begin
         state_nxt = eeprom_pkg::ST_IDLE;
         oe_n_nxt = 1'b1;
         if (state_r == eeprom_pkg::ST_WDATA && cnt_r <= 4'h1 && have_r) begin
            busy_nxt = 1'b1;
            timer_nxt = WRITE_CYCLES[eeprom_pkg::TIMER_W-1:0];
            wr_idx_nxt = 5'h00;
            wpage_nxt = addr_r[8:4];
         end else begin
            pvalid_nxt = '0;
            have_nxt = 1'b0;
         end
      end else begin
         case (state_r)
            eeprom_pkg::ST_DEVADDR, eeprom_pkg::ST_WORDADDR, eeprom_pkg::ST_WDATA: begin
               if (scl_rise && cnt_r < eeprom_pkg::BIT_COUNT_FULL) begin
                  shift_nxt = {shift_r[6:0], sda_s};
                  cnt_nxt = cnt_r + 4'h1;
               end else if (scl_fall && cnt_r == eeprom_pkg::BIT_COUNT_FULL) begin
                  cnt_nxt = 4'h0;
                  if (state_r == eeprom_pkg::ST_DEVADDR) begin
                     if (sel_match) begin
                        oe_n_nxt = 1'b0;
                        rw_nxt = shift_r[eeprom_pkg::SLV_RW];
                        addr_nxt = {shift_r[eeprom_pkg::SLV_MSB], addr_r[7:0]};
                        state_nxt = eeprom_pkg::ST_DEVACK;
                     end else begin
                        state_nxt = eeprom_pkg::ST_WAIT;
                     end
                  end else if (state_r == eeprom_pkg::ST_WORDADDR) begin
                     oe_n_nxt = 1'b0;
                     addr_nxt = {addr_r[8], shift_r};
                     state_nxt = eeprom_pkg::ST_WORDACK;
                  end else if (wp_s && addr_r[8]) begin
                     state_nxt = eeprom_pkg::ST_WAIT;
                     pvalid_nxt = '0;
                     have_nxt = 1'b0;
                  end else begin
                     // Same slot overwritten after wrap
                     oe_n_nxt = 1'b0;
                     pbuf_nxt[addr_r[3:0]] = shift_r;
                     pvalid_nxt[addr_r[3:0]] = 1'b1;
                     addr_nxt = {addr_r[8:4], addr_r[3:0] + 4'h1};
                     have_nxt = 1'b1;
                     state_nxt = eeprom_pkg::ST_WDACK;
                  end
               end
            end
            eeprom_pkg::ST_DEVACK: begin
               if (scl_fall) begin
                  if (rw_r) begin
                     oe_n_nxt = rd_byte[7];
                     tx_nxt = {rd_byte[6:0], 1'b0};
                     cnt_nxt = 4'h1;
                     state_nxt = eeprom_pkg::ST_RDATA;
                  end else begin
                     oe_n_nxt = 1'b1;
                     state_nxt = eeprom_pkg::ST_WORDADDR;
                  end
               end
            end
            eeprom_pkg::ST_WORDACK, eeprom_pkg::ST_WDACK: begin
               if (scl_fall) begin
                  oe_n_nxt = 1'b1;
                  state_nxt = eeprom_pkg::ST_WDATA;
               end
            end
            eeprom_pkg::ST_RDATA: begin
               if (scl_fall) begin
                  if (cnt_r == eeprom_pkg::BIT_COUNT_FULL) begin
                     oe_n_nxt = 1'b1;
                     addr_nxt = addr_r + 9'h001;
                     cnt_nxt = 4'h0;
                     state_nxt = eeprom_pkg::ST_RACK;
                  end else begin
                     oe_n_nxt = tx_r[7];
                     tx_nxt = {tx_r[6:0], 1'b0};
                     cnt_nxt = cnt_r + 4'h1;
                  end
               end
            end
            eeprom_pkg::ST_RACK: begin
               if (scl_rise) begin
                  if (sda_s) begin
                     state_nxt = eeprom_pkg::ST_WAIT;
                  end else begin
                     ack_seen_nxt = 1'b1;
                  end
               end else if (scl_fall && ack_seen_r) begin
                  ack_seen_nxt = 1'b0;
                  oe_n_nxt = rd_byte[7];
                  tx_nxt = {rd_byte[6:0], 1'b0};
                  cnt_nxt = 4'h1;
                  state_nxt = eeprom_pkg::ST_RDATA;
               end
            end
            default: begin
               state_nxt = state_r;
            end
         endcase
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r <= eeprom_pkg::ST_IDLE;
         cnt_r <= 4'h0;
         shift_r <= 8'h00;
         tx_r <= 8'h00;
         addr_r <= 9'h000;
         rw_r <= 1'b0;
         oe_n_r <= 1'b1;
         busy_r <= 1'b0;
         ack_seen_r <= 1'b0;
         have_r <= 1'b0;
         timer_r <= 20'h00000;
         wr_idx_r <= 5'h10;
         wpage_r <= 5'h00;
         pvalid_r <= '0;
         pbuf_r <= '{default: 8'h00};
         // Same level as synchroniser reset, no false fall
         scl_d_r <= 1'b0;
         sda_d_r <= 1'b0;
         sda_out <= 1'b0;
         sda_oe_n <= 1'b1;
         write_busy <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         shift_r <= shift_nxt;
         tx_r <= tx_nxt;
         addr_r <= addr_nxt;
         rw_r <= rw_nxt;
         oe_n_r <= oe_n_nxt;
         busy_r <= busy_nxt;
         ack_seen_r <= ack_seen_nxt;
         have_r <= have_nxt;
         timer_r <= timer_nxt;
         wr_idx_r <= wr_idx_nxt;
         wpage_r <= wpage_nxt;
         pvalid_r <= pvalid_nxt;
         pbuf_r <= pbuf_nxt;
         scl_d_r <= scl_s;
         sda_d_r <= sda_s;
         sda_out <= 1'b0;
         sda_oe_n <= oe_n_nxt;
         write_busy <= busy_nxt;
      end
   end

   // ****************************************
   // Array write, one slot per cycle
   // ****************************************
   always_ff @(posedge clk) begin
      if (mem_we) begin
         mem[{wpage_r, wr_idx_r[3:0]}] <= pbuf_r[wr_idx_r[3:0]];
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   logic byte_end;
   assign byte_end = scl_fall && cnt_r == eeprom_pkg::BIT_COUNT_FULL && !busy_r
      && !start_ev && !stop_ev;

   sequence s_commit;
      stop_ev && !busy_r && state_r == eeprom_pkg::ST_WDATA && cnt_r <= 4'h1 && have_r;
   endsequence

   sequence s_busy_quiet;
      write_busy && sda_oe_n [*8];
   endsequence

   a_commit_busy: assert property (s_commit |=> s_busy_quiet)
      else $error("write cycle not started after valid stop");
   a_early_stop: assert property (stop_ev && !busy_r && state_r == eeprom_pkg::ST_WDATA
      && cnt_r > 4'h1 |=> !busy_r && pvalid_r == '0)
      else $error("mid-byte stop did not discard write");
   a_busy_no_ack: assert property (busy_r |=> sda_oe_n)
      else $error("SDA driven during write cycle");
   a_sel_mismatch: assert property (byte_end && state_r == eeprom_pkg::ST_DEVADDR
      && !sel_match |=> sda_oe_n && state_r == eeprom_pkg::ST_WAIT)
      else $error("acknowledged wrong select bits");
   a_word_load: assert property (byte_end && state_r == eeprom_pkg::ST_WORDADDR
      |=> addr_r == {$past(addr_r[8]), $past(shift_r)} && !sda_oe_n)
      else $error("word address not loaded");
   a_page_wrap: assert property (byte_end && state_r == eeprom_pkg::ST_WDATA
      && !(wp_s && addr_r[8]) |=> addr_r[8:4] == $past(addr_r[8:4])
      && addr_r[3:0] == $past(addr_r[3:0]) + 4'h1)
      else $error("page counter did not wrap in page");
   a_protect_nack: assert property (byte_end && state_r == eeprom_pkg::ST_WDATA
      && wp_s && addr_r[8] |=> sda_oe_n && !have_r [*2])
      else $error("protected write acknowledged");
   a_read_inc: assert property (byte_end && state_r == eeprom_pkg::ST_RDATA
      |=> addr_r == $past(addr_r) + 9'h001 && sda_oe_n)
      else $error("read address not advanced");
   a_nack_ends: assert property (scl_rise && sda_s && state_r == eeprom_pkg::ST_RACK
      && !busy_r && !start_ev && !stop_ev |=> state_r == eeprom_pkg::ST_WAIT)
      else $error("read continued after nack");

endmodule

// ===== twowire_master_model.sv
// Behavioural two-wire bus master that drives SCL and its share of SDA.
// Assumes the bench resolves SDA from all drivers with a pull-up.
`timescale 1ns/100ps
module twowire_master_model (
   // Clock
   input wire logic clk,
   // Bus
   output logic scl,
   output logic sda_drv,
   input wire logic sda
);
   // ****
   // Bus timing, 10 clk per SCL period for data bits, 14 clk for start and stop
   // ****
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Data set mid-low, sampled mid-high
   task automatic bit_cycle(input logic d, output logic s);
      scl = 1'b0;
      tick(3);
      sda_drv = d;
      tick(3);
      scl = 1'b1;
      tick(2);
      s = sda;
      tick(2);
   endtask

   // Start is cond(1,0), stop is cond(0,1), SCL stays high after
   task automatic cond(input logic a0, input logic a1);
      scl = 1'b0;
      tick(3);
      sda_drv = a0;
      tick(3);
      scl = 1'b1;
      tick(4);
      sda_drv = a1;
      tick(4);
   endtask

   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(b[i], s);
      end
      bit_cycle(1'b1, s);
      ack = (s === 1'b0);
   endtask

   task automatic recv_byte(input logic give_ack, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(1'b1, b[i]);
      end
      bit_cycle(!give_ack, s);
   endtask
endmodule

// ===== serial_eeprom_twowire_slave_test.sv
// Self-checking bench for the two-wire serial memory slave.
// Assumes the master model owns SCL; SDA is resolved here with a pull-up.
`timescale 1ns/100ps
`define CHECK(g, w) begin tests_run++; if ((g) !== (w)) begin fails++; \
   $display("[ERR] %0t got %h want %h", $time, (g), (w)); end end
module serial_eeprom_twowire_slave_test;
   localparam logic [3:0] TYPE_ID = 4'h5; // Arbitrary value
   logic clk, rst, scl, sda, sda_drv, sda_out, sda_oe_n, write_busy;
   logic write_protect, chip_select_pin_low, chip_select_pin_high;
   logic [7:0] exp_mem [512];
   int fails = 0;
   int tests_run = 0;

   assign sda = sda_drv & (sda_oe_n | sda_out);
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   twowire_master_model twowire_master_model_i (.clk(clk), .scl(scl), .sda_drv(sda_drv),
      .sda(sda));
   twowire_eeprom_slave #(.DEVICE_TYPE_ID(TYPE_ID), .WRITE_CYCLES(400)) twowire_eeprom_slave_i (
      .clk(clk), .rst(rst), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
      .write_protect(write_protect), .chip_select_pin_low(chip_select_pin_low),
      .chip_select_pin_high(chip_select_pin_high), .write_busy(write_busy));

   // ****
   // Bus helpers
   // ****
   task automatic tick(input int n);
      twowire_master_model_i.tick(n);
   endtask
   task automatic tx(input logic [7:0] b, output logic ack);
      twowire_master_model_i.send_byte(b, ack);
   endtask
   task automatic bus_cond(input logic a0, input logic a1);
      twowire_master_model_i.cond(a0, a1);
   endtask
   function automatic logic [7:0] slave_byte(input logic msb, input logic rw);
      return {TYPE_ID, chip_select_pin_high, chip_select_pin_low, msb, rw};
   endfunction

   task automatic wrap_up();
      $display("fails=%0d tests_run=%0d", fails, tests_run);
      if (fails == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic poll_ready();
      logic k, b0;
      for (int i = 0; i < 20; i++) begin
         b0 = write_busy;
         bus_cond(1'b1, 1'b0);
         tx(slave_byte(1'b0, 1'b0), k);
         if (b0 === 1'b1 && write_busy === 1'b1) `CHECK(k, 1'b0)
         bus_cond(1'b0, 1'b1);
         if (k === 1'b1) begin
            `CHECK(write_busy, 1'b0)
            return;
         end
      end
      fails++;
      wrap_up();
   endtask

   task automatic addr_phase(input logic [8:0] ad);
      logic k;
      bus_cond(1'b1, 1'b0);
      tx(slave_byte(ad[8], 1'b0), k);
      `CHECK(k, 1'b1)
      tx(ad[7:0], k);
      `CHECK(k, 1'b1)
   endtask

   task automatic write_page(input logic [8:0] ad, input int n, input logic [7:0] base,
      input logic ok);
      logic k;
      logic [8:0] loc;
      addr_phase(ad);
      for (int i = 0; i < n; i++) begin
         tx(base + 8'(i), k);
         `CHECK(k, ok)
         loc = {ad[8:4], ad[3:0] + 4'(i)};
         if (ok) exp_mem[loc] = base + 8'(i);
      end
      bus_cond(1'b0, 1'b1);
      tick(2);
      `CHECK(write_busy, ok)
      poll_ready();
   endtask

   task automatic read_seq(input logic [8:0] ad, input logic rnd, input int n);
      logic k;
      logic [7:0] b;
      if (rnd) addr_phase(ad);
      bus_cond(1'b1, 1'b0);
      tx(slave_byte(ad[8], 1'b1), k);
      `CHECK(k, 1'b1)
      for (int i = 0; i < n; i++) begin
         twowire_master_model_i.recv_byte(i < n - 1, b);
         `CHECK(b, exp_mem[9'(ad + 9'(i))])
      end
      `CHECK(sda_oe_n, 1'b1)
      bus_cond(1'b0, 1'b1);
   endtask

   // ****
   // Scenarios
   // ****
   task automatic sc_select();
      logic k;
      for (int p = 0; p < 2; p++) begin
         {chip_select_pin_high, chip_select_pin_low} = (p == 0) ? 2'b10 : 2'b01;
         tick(4);
         for (int j = 0; j < 5; j++) begin
            bus_cond(1'b1, 1'b0);
            tx({(j == 4) ? ~TYPE_ID : TYPE_ID, 2'(j), 2'b00}, k);
            `CHECK(k, 2'(j) == {chip_select_pin_high, chip_select_pin_low} && j < 4)
            bus_cond(1'b0, 1'b1);
         end
      end
      {chip_select_pin_high, chip_select_pin_low} = 2'b10;
      tick(4);
   endtask

   task automatic sc_pages();
      write_page(9'h00A, 12, 8'h10, 1'b1);
      write_page(9'h1FF, 18, 8'hA0, 1'b1);
      read_seq(9'h1F0, 1'b1, 17);
      read_seq(9'h001, 1'b0, 2);
   endtask

   task automatic sc_abort();
      logic s, k;
      addr_phase(9'h005);
      tx(8'hEE, k);
      `CHECK(k, 1'b1)
      for (int i = 0; i < 3; i++) twowire_master_model_i.bit_cycle(1'b0, s);
      bus_cond(1'b0, 1'b1);
      tick(3);
      `CHECK(write_busy, 1'b0)
      addr_phase(9'h003);
      bus_cond(1'b0, 1'b1);
      tick(3);
      `CHECK(write_busy, 1'b0)
      read_seq(9'h003, 1'b0, 3);
   endtask

   task automatic sc_protect();
      write_page(9'h150, 1, 8'h33, 1'b1);
      tick(1);
      write_protect = 1'b1;
      write_page(9'h150, 1, 8'h77, 1'b0);
      write_page(9'h0FF, 1, 8'h66, 1'b1);
      read_seq(9'h150, 1'b1, 1);
      read_seq(9'h0FF, 1'b1, 1);
      tick(1);
      write_protect = 1'b0;
   endtask

   initial begin
      rst = 1'b1;
      write_protect = 1'b0;
      chip_select_pin_low = 1'b0;
      chip_select_pin_high = 1'b1;
      repeat (5) @(posedge clk);
      #1 rst = 1'b0;
      tick(4);
      sc_select();
      sc_pages();
      sc_abort();
      sc_protect();
      wrap_up();
   end
endmodule
